// [rtl/acm_top.sv]
// Converter register block: calibration words, filter results and input select.
// Assumes the core drives the register port synchronously to mclk and that the
// filters present a 24-bit result with a one-cycle load pulse.
//
// Functional notes
// RQ1 - Offset middle byte at 0xBB, read/write, holds bits 15..8, resets zero.
// RQ2 - Offset low byte at 0xBA, read/write, holds bits 7..0, resets zero.
// RQ3 - Gain high byte at 0xAD, read/write, bits 23..16, resets to 0x80.
// RQ4 - Gain middle byte at 0xAC, read/write, bits 15..8, resets zero.
// RQ5 - Gain low byte at 0xAB, read/write, holds bits 7..0.
// RQ6 - Main filter result bits 23..16 readable at 0xC5, reset zero.
// RQ7 - Main filter result bits 7..0 readable at 0xC3.
// RQ8 - Fast filter result bits 23..16 readable at 0xFE.
// RQ9 - Fast filter result bits 7..0 readable at 0xFC, reset zero.
// RQ10 - Positive and negative inputs selected independently from one select register.
// RQ11 - Each input routes to one of eight pins, ground or temperature sensor.
// RQ12 - Software picks ground on one input for single-ended measurement.
// RQ13 - Temperature sensor may be chosen on either input.
// RQ14 - Temperature sensor enables itself whenever either selection picks it.
// RQ15 - Offset high byte, read/write, holds bits 23..16, resets zero.
// RQ16 - Middle result byte of each filter readable beside high and low.
// RQ17 - Calibration bytes combine into one 24-bit offset and gain word.
module acm_top
  import acm_pkg::*;
#(
  parameter int unsigned RESULT_W = 24
) (
  // Clock, reset and clock enable.
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // Register port.
  input  wire logic [7:0]            sfr_addr,
  input  wire logic [7:0]            sfr_wdata,
  input  wire logic                  sfr_wr,
  input  wire logic                  sfr_rd,
  output logic [7:0]                 sfr_rdata,
  output logic                       sfr_rvalid,
  // Filter results.
  input  wire logic                  main_load,
  input  wire logic [RESULT_W-1:0]   main_data,
  input  wire logic                  fast_load,
  input  wire logic [RESULT_W-1:0]   fast_data,
  // Calibration words.
  output logic [ACM_WORD_W-1:0]      offset_word,
  output logic [ACM_WORD_W-1:0]      gain_word,
  // Input multiplexer.
  output logic [ACM_PIN_N-1:0]       pos_pin_sel,
  output logic                       pos_to_ground,
  output logic                       pos_to_temp,
  output logic [ACM_PIN_N-1:0]       neg_pin_sel,
  output logic                       neg_to_ground,
  output logic                       neg_to_temp,
  output logic                       temp_sensor_en
);

  if (RESULT_W != ACM_WORD_W) begin : g_chk
    $error("Result width must match the 24-bit register layout.");
  end

  acm_sfr_if sfr ();

  logic [7:0] main_high_ff;
  logic [7:0] main_mid_ff;
  logic [7:0] main_low_ff;
  logic [7:0] fast_high_ff;
  logic [7:0] fast_mid_ff;
  logic [7:0] fast_low_ff;
  logic [7:0] select_ff;
  logic [7:0] sfr_rdata_ff;
  logic       sfr_rvalid_ff;
  logic [7:0] nxt_rdata;
  acm_src_t   pos_kind;
  acm_src_t   neg_kind;

  // A filter load beats a software write in the same cycle, so no result is lost.
  function automatic logic [7:0] upd_byte(input logic [7:0] cur,
                                          input logic       load,
                                          input logic [7:0] hw,
                                          input logic       hit,
                                          input logic [7:0] sw);
    if (load) begin
      return hw;
    end
    if (hit) begin
      return sw;
    end
    return cur;
  endfunction : upd_byte

  // Write strobe for one address.
  function automatic logic wr_hit(input logic [7:0] a);
    return sfr_wr && (sfr_addr == a);
  endfunction : wr_hit

  // Register writes fan out to the calibration banks.
  assign sfr.ce    = ce;
  assign sfr.wr    = sfr_wr;
  assign sfr.addr  = sfr_addr;
  assign sfr.wdata = sfr_wdata;

  // Offset calibration bank, all bytes clear at reset.
  acm_cal_word #(
    .ADDR_HIGH (ACM_ADDR_OFS_HIGH),
    .ADDR_MID  (ACM_ADDR_OFS_MID),
    .ADDR_LOW  (ACM_ADDR_OFS_LOW),
    .RST_HIGH  (ACM_RST_ZERO)
  ) u_offset (
    .mclk   (mclk),
    .resetn (resetn),
    .bus    (sfr.sink),
    .word   (offset_word)
  ); // see RQ1 see RQ2 see RQ15

  // Gain calibration bank, high byte starts at unity scale.
  acm_cal_word #(
    .ADDR_HIGH (ACM_ADDR_GAIN_HIGH),
    .ADDR_MID  (ACM_ADDR_GAIN_MID),
    .ADDR_LOW  (ACM_ADDR_GAIN_LOW),
    .RST_HIGH  (ACM_RST_GAIN_HIGH)
  ) u_gain (
    .mclk   (mclk),
    .resetn (resetn),
    .bus    (sfr.sink),
    .word   (gain_word)
  ); // see RQ3 see RQ4 see RQ5

  // Main filter result bytes.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      main_high_ff <= ACM_RST_ZERO;
      main_mid_ff  <= ACM_RST_ZERO;
      main_low_ff  <= ACM_RST_ZERO;
    end else if (ce) begin
      main_high_ff <= upd_byte(main_high_ff, main_load, main_data[ACM_HIGH_LSB +: ACM_BYTE_W],
                               wr_hit(ACM_ADDR_MAIN_HIGH), sfr_wdata); // see RQ6
      main_mid_ff  <= upd_byte(main_mid_ff, main_load, main_data[ACM_MID_LSB +: ACM_BYTE_W],
                               wr_hit(ACM_ADDR_MAIN_MID), sfr_wdata); // see RQ16
      main_low_ff  <= upd_byte(main_low_ff, main_load, main_data[ACM_LOW_LSB +: ACM_BYTE_W],
                               wr_hit(ACM_ADDR_MAIN_LOW), sfr_wdata); // see RQ7
    end
  end

  // Fast filter result bytes.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fast_high_ff <= ACM_RST_ZERO;
      fast_mid_ff  <= ACM_RST_ZERO;
      fast_low_ff  <= ACM_RST_ZERO;
    end else if (ce) begin
      fast_high_ff <= upd_byte(fast_high_ff, fast_load, fast_data[ACM_HIGH_LSB +: ACM_BYTE_W],
                               wr_hit(ACM_ADDR_FAST_HIGH), sfr_wdata); // see RQ8
      fast_mid_ff  <= upd_byte(fast_mid_ff, fast_load, fast_data[ACM_MID_LSB +: ACM_BYTE_W],
                               wr_hit(ACM_ADDR_FAST_MID), sfr_wdata); // see RQ16
      fast_low_ff  <= upd_byte(fast_low_ff, fast_load, fast_data[ACM_LOW_LSB +: ACM_BYTE_W],
                               wr_hit(ACM_ADDR_FAST_LOW), sfr_wdata); // see RQ9
    end
  end

  // Input select register; both fields are written together.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      select_ff <= ACM_RST_SELECT;
    end else if (ce && wr_hit(ACM_ADDR_SELECT)) begin
      select_ff <= sfr_wdata; // see RQ10
    end
  end

  // Positive input decoder.
  acm_mux_dec u_pos_dec (
    .code    (select_ff[ACM_SEL_POS_LSB +: ACM_CODE_W]),
    .kind    (pos_kind),
    .pin_sel (pos_pin_sel)
  ); // see RQ10 see RQ11

  // Negative input decoder, independent of the positive one.
  acm_mux_dec u_neg_dec (
    .code    (select_ff[ACM_SEL_NEG_LSB +: ACM_CODE_W]),
    .kind    (neg_kind),
    .pin_sel (neg_pin_sel)
  ); // see RQ10 see RQ11

  // Routing flags; the sensor powers up whenever either side picks it.
  assign pos_to_ground  = (pos_kind == acm_src_ground); // see RQ12
  assign neg_to_ground  = (neg_kind == acm_src_ground); // see RQ12
  assign pos_to_temp    = (pos_kind == acm_src_temp); // see RQ13
  assign neg_to_temp    = (neg_kind == acm_src_temp); // see RQ13
  assign temp_sensor_en = pos_to_temp || neg_to_temp; // see RQ14

  // Read data selection; unmapped addresses read as zero.
  always_comb begin
    unique case (sfr_addr)
      ACM_ADDR_OFS_HIGH:  nxt_rdata = offset_word[ACM_HIGH_LSB +: ACM_BYTE_W]; // see RQ15
      ACM_ADDR_OFS_MID:   nxt_rdata = offset_word[ACM_MID_LSB +: ACM_BYTE_W]; // see RQ1
      ACM_ADDR_OFS_LOW:   nxt_rdata = offset_word[ACM_LOW_LSB +: ACM_BYTE_W]; // see RQ2
      ACM_ADDR_GAIN_HIGH: nxt_rdata = gain_word[ACM_HIGH_LSB +: ACM_BYTE_W]; // see RQ3
      ACM_ADDR_GAIN_MID:  nxt_rdata = gain_word[ACM_MID_LSB +: ACM_BYTE_W]; // see RQ4
      ACM_ADDR_GAIN_LOW:  nxt_rdata = gain_word[ACM_LOW_LSB +: ACM_BYTE_W]; // see RQ5
      ACM_ADDR_MAIN_HIGH: nxt_rdata = main_high_ff; // see RQ6
      ACM_ADDR_MAIN_MID:  nxt_rdata = main_mid_ff; // see RQ16
      ACM_ADDR_MAIN_LOW:  nxt_rdata = main_low_ff; // see RQ7
      ACM_ADDR_FAST_HIGH: nxt_rdata = fast_high_ff; // see RQ8
      ACM_ADDR_FAST_MID:  nxt_rdata = fast_mid_ff; // see RQ16
      ACM_ADDR_FAST_LOW:  nxt_rdata = fast_low_ff; // see RQ9
      ACM_ADDR_SELECT:    nxt_rdata = select_ff;
      default:            nxt_rdata = ACM_READ_UNMAPPED;
    endcase
  end

  // Read answer is registered one cycle after the strobe.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata_ff  <= ACM_RST_ZERO;
      sfr_rvalid_ff <= 1'b0;
    end else if (ce) begin
      sfr_rvalid_ff <= sfr_rd;
      if (sfr_rd) begin
        sfr_rdata_ff <= nxt_rdata;
      end
    end
  end

  assign sfr_rdata  = sfr_rdata_ff;
  assign sfr_rvalid = sfr_rvalid_ff;

  // Offset middle byte of the assembled word follows a write.
  a_ofs_mid_write: assert property (@(posedge mclk) disable iff (!resetn) // see RQ1
    (ce && sfr_wr && sfr_addr == ACM_ADDR_OFS_MID)
    |=> (offset_word[15:8] == $past(sfr_wdata)))
    else $error("Offset middle byte did not take the write.");

  // Offset low byte follows a write and leaves the others alone.
  a_ofs_low_write: assert property (@(posedge mclk) disable iff (!resetn) // see RQ2
    (ce && sfr_wr && sfr_addr == ACM_ADDR_OFS_LOW)
    |=> (offset_word[7:0] == $past(sfr_wdata)) && (offset_word[23:8] == $past(offset_word[23:8])))
    else $error("Offset low byte write wrong.");

  // Gain high byte comes out of reset at unity scale.
  a_gain_high_rst: assert property (@(posedge mclk) disable iff (!resetn) // see RQ3
    $rose(resetn) |-> (gain_word == 24'h800000))
    else $error("Gain word reset value wrong.");

  // Gain middle byte takes a write.
  a_gain_mid_write: assert property (@(posedge mclk) disable iff (!resetn) // see RQ4
    (ce && sfr_wr && sfr_addr == ACM_ADDR_GAIN_MID)
    |=> (gain_word[15:8] == $past(sfr_wdata)))
    else $error("Gain middle byte did not take the write.");

  // Gain low byte reads back two cycles after a write.
  a_gain_low_rdbk: assert property (@(posedge mclk) disable iff (!resetn) // see RQ5
    (ce && sfr_wr && sfr_addr == ACM_ADDR_GAIN_LOW)
    ##1 (ce && sfr_rd && sfr_addr == ACM_ADDR_GAIN_LOW && !sfr_wr)
    |=> sfr_rvalid && (sfr_rdata == $past(sfr_wdata, 2)))
    else $error("Gain low byte readback wrong.");

  // Main high byte takes the filter result even against a write.
  a_main_high_load: assert property (@(posedge mclk) disable iff (!resetn) // see RQ6
    (ce && main_load) |=> (main_high_ff == $past(main_data[23:16])))
    else $error("Main high byte lost the filter result.");

  // Main low byte reads back what the filter loaded.
  a_main_low_read: assert property (@(posedge mclk) disable iff (!resetn) // see RQ7
    (ce && main_load) ##1 (ce && sfr_rd && sfr_addr == ACM_ADDR_MAIN_LOW && !main_load && !sfr_wr)
    |=> (sfr_rdata == $past(main_data[7:0], 2)))
    else $error("Main low byte readback wrong.");

  // Fast high byte takes the filter result.
  a_fast_high_load: assert property (@(posedge mclk) disable iff (!resetn) // see RQ8
    (ce && fast_load) |=> (fast_high_ff == $past(fast_data[23:16])))
    else $error("Fast high byte lost the filter result.");

  // Fast low byte reads back through the port.
  a_fast_low_read: assert property (@(posedge mclk) disable iff (!resetn) // see RQ9
    (ce && fast_load) ##1 (ce && sfr_rd && sfr_addr == ACM_ADDR_FAST_LOW && !fast_load && !sfr_wr)
    |=> (sfr_rdata == $past(fast_data[7:0], 2)))
    else $error("Fast low byte readback wrong.");

  // Middle result bytes follow their filters.
  a_result_mid: assert property (@(posedge mclk) disable iff (!resetn) // see RQ16
    (ce && main_load && fast_load)
    |=> (main_mid_ff == $past(main_data[15:8])) && (fast_mid_ff == $past(fast_data[15:8])))
    else $error("Middle result byte wrong.");

  // Each field of the select register steers only its own input.
  a_select_fields: assert property (@(posedge mclk) disable iff (!resetn) // see RQ10 see RQ11 see RQ12
    (ce && sfr_wr && sfr_addr == ACM_ADDR_SELECT && sfr_wdata[7:4] == 4'h3 && sfr_wdata[3:0] == 4'h9)
    |=> (pos_pin_sel == 8'h08) && neg_to_ground && !pos_to_ground && (neg_pin_sel == 8'h00))
    else $error("Input selection decode wrong.");

  // The sensor is enabled exactly when either side selects it.
  a_temp_enable: assert property (@(posedge mclk) disable iff (!resetn) // see RQ13 see RQ14
    (ce && sfr_wr && sfr_addr == ACM_ADDR_SELECT)
    |=> (temp_sensor_en == ($past(sfr_wdata[7:4]) == 4'hf || $past(sfr_wdata[3:0]) == 4'hf)))
    else $error("Temperature sensor enable wrong.");

  // Offset high byte reads back from the assembled word.
  a_ofs_high_read: assert property (@(posedge mclk) disable iff (!resetn) // see RQ15 see RQ17
    (ce && sfr_rd && sfr_addr == ACM_ADDR_OFS_HIGH)
    |=> sfr_rvalid && (sfr_rdata == $past(offset_word[23:16])))
    else $error("Offset high byte readback wrong.");

  // A low clock enable freezes the calibration words, main high byte and select register.
  a_ce_freeze: assert property (@(posedge mclk) disable iff (!resetn)
    !ce |=> $stable(offset_word) && $stable(gain_word) && $stable(main_high_ff) && $stable(select_ff))
    else $error("State changed while clock enable was low.");

  // The read answer stands for exactly one cycle after each read strobe.
  a_rvalid_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    ce |=> (sfr_rvalid == $past(sfr_rd)))
    else $error("Read valid did not follow the read strobe.");

  // Read data holds its last value until the next read.
  a_rdata_hold: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && !sfr_rd) |=> $stable(sfr_rdata))
    else $error("Read data changed without a read.");

  // A low clock enable also freezes the read answer and the low result bytes.
  a_ce_freeze_read: assert property (@(posedge mclk) disable iff (!resetn)
    !ce |=> $stable(sfr_rvalid) && $stable(sfr_rdata) && $stable(fast_low_ff) && $stable(main_low_ff))
    else $error("Read answer changed while clock enable was low.");

  // An address with no register behind it reads as zero.
  a_unmapped_read: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && sfr_rd && sfr_addr == 8'h00) |=> (sfr_rdata == ACM_READ_UNMAPPED))
    else $error("Unmapped address did not read as zero.");

  // A pin code on the positive side closes exactly that pin switch.
  a_pos_pin_route: assert property (@(posedge mclk) disable iff (!resetn) // see RQ11
    (ce && sfr_wr && sfr_addr == ACM_ADDR_SELECT && !sfr_wdata[7])
    |=> (pos_pin_sel == (8'h01 << $past(sfr_wdata[6:4]))) && !pos_to_ground && !pos_to_temp)
    else $error("Positive pin routing wrong.");

  // A pin code on the negative side closes exactly that pin switch.
  a_neg_pin_route: assert property (@(posedge mclk) disable iff (!resetn) // see RQ11
    (ce && sfr_wr && sfr_addr == ACM_ADDR_SELECT && !sfr_wdata[3])
    |=> (neg_pin_sel == (8'h01 << $past(sfr_wdata[2:0]))) && !neg_to_ground && !neg_to_temp)
    else $error("Negative pin routing wrong.");

  // Codes past the last pin, other than the sensor code, put the positive side on ground.
  a_pos_ground: assert property (@(posedge mclk) disable iff (!resetn) // see RQ11
    (ce && sfr_wr && sfr_addr == ACM_ADDR_SELECT && sfr_wdata[7] && sfr_wdata[7:4] != ACM_CODE_TEMP)
    |=> pos_to_ground && !pos_to_temp && (pos_pin_sel == 8'h00))
    else $error("Positive ground routing wrong.");

  // Codes past the last pin, other than the sensor code, put the negative side on ground.
  a_neg_ground: assert property (@(posedge mclk) disable iff (!resetn) // see RQ11
    (ce && sfr_wr && sfr_addr == ACM_ADDR_SELECT && sfr_wdata[3] && sfr_wdata[3:0] != ACM_CODE_TEMP)
    |=> neg_to_ground && !neg_to_temp && (neg_pin_sel == 8'h00))
    else $error("Negative ground routing wrong.");

endmodule : acm_top

// [shared/acm_pkg.sv]
// Constants shared by the converter calibration, result and input-select registers.
// Assumes an 8-bit special-function-register space and 24-bit converter words.
package acm_pkg;

  // Data widths.
  localparam int unsigned ACM_BYTE_W = 8;
  localparam int unsigned ACM_WORD_W = 24;
  localparam int unsigned ACM_PIN_N  = 8;
  localparam int unsigned ACM_CODE_W = 4;

  // Byte positions inside a 24-bit word.
  localparam int unsigned ACM_HIGH_LSB = 16;
  localparam int unsigned ACM_MID_LSB  = 8;
  localparam int unsigned ACM_LOW_LSB  = 0;

  // Register addresses in special-function-register space.
  localparam logic [7:0] ACM_ADDR_GAIN_LOW   = 8'hab;
  localparam logic [7:0] ACM_ADDR_GAIN_MID   = 8'hac;
  localparam logic [7:0] ACM_ADDR_GAIN_HIGH  = 8'had;
  localparam logic [7:0] ACM_ADDR_OFS_LOW    = 8'hba;
  localparam logic [7:0] ACM_ADDR_OFS_MID    = 8'hbb;
  localparam logic [7:0] ACM_ADDR_OFS_HIGH   = 8'hbc;
  localparam logic [7:0] ACM_ADDR_MAIN_LOW   = 8'hc3;
  localparam logic [7:0] ACM_ADDR_MAIN_MID   = 8'hc4;
  localparam logic [7:0] ACM_ADDR_MAIN_HIGH  = 8'hc5;
  localparam logic [7:0] ACM_ADDR_SELECT     = 8'hc6;
  localparam logic [7:0] ACM_ADDR_FAST_LOW   = 8'hfc;
  localparam logic [7:0] ACM_ADDR_FAST_MID   = 8'hfd;
  localparam logic [7:0] ACM_ADDR_FAST_HIGH  = 8'hfe;

  // Reset values and the value read from unmapped addresses.
  localparam logic [7:0] ACM_RST_ZERO      = 8'h00;
  localparam logic [7:0] ACM_RST_GAIN_HIGH = 8'h80;
  localparam logic [7:0] ACM_RST_SELECT    = 8'h00;
  localparam logic [7:0] ACM_READ_UNMAPPED = 8'h00;

  // Fields of the input select register.
  localparam int unsigned ACM_SEL_POS_LSB = 4;
  localparam int unsigned ACM_SEL_NEG_LSB = 0;

  // Input select codes.
  localparam logic [3:0] ACM_CODE_PIN_LAST = 4'h7;
  localparam logic [3:0] ACM_CODE_TEMP     = 4'hf;

  // Source that one converter input is connected to.
  typedef enum logic [1:0] {
    acm_src_pin    = 2'b00,
    acm_src_ground = 2'b01,
    acm_src_temp   = 2'b10
  } acm_src_t;

endpackage : acm_pkg

// [shared/acm_sfr_if.sv]
// Write side of the special-function-register port, passed to the calibration banks.
// Assumes one driver (the top module) and any number of sinks.
interface acm_sfr_if;
  logic       ce;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;

  modport drv  (output ce, output wr, output addr, output wdata);
  modport sink (input ce, input wr, input addr, input wdata);
endinterface : acm_sfr_if

// [rtl/acm_mux_dec.sv]
// Decoder for one converter input selection code.
// Assumes the code comes from a register; output is purely combinational.
module acm_mux_dec
  import acm_pkg::*;
(
  // Selection code.
  input  wire logic [ACM_CODE_W-1:0] code,
  // Decoded routing.
  output acm_src_t                   kind,
  output logic [ACM_PIN_N-1:0]       pin_sel
);

  // Maps a code to the source kind; unused codes fall back to analog ground.
  function automatic acm_src_t decode_kind(input logic [ACM_CODE_W-1:0] c);
    if (c <= ACM_CODE_PIN_LAST) begin
      return acm_src_pin;
    end
    if (c == ACM_CODE_TEMP) begin
      return acm_src_temp;
    end
    return acm_src_ground;
  endfunction : decode_kind

  // One pin switch closes only for a pin code.
  always_comb begin
    kind    = decode_kind(code); // see RQ11
    pin_sel = '0;
    if (kind == acm_src_pin) begin
      pin_sel[code[2:0]] = 1'b1;
    end
  end

endmodule : acm_mux_dec

// [rtl/acm_cal_word.sv]
// Three-byte calibration word written byte by byte from the register port.
// Assumes the top module decodes reads; this bank only stores writes.
module acm_cal_word
  import acm_pkg::*;
#(
  parameter logic [7:0] ADDR_HIGH = ACM_ADDR_OFS_HIGH,
  parameter logic [7:0] ADDR_MID  = ACM_ADDR_OFS_MID,
  parameter logic [7:0] ADDR_LOW  = ACM_ADDR_OFS_LOW,
  parameter logic [7:0] RST_HIGH  = ACM_RST_ZERO
) (
  // Clock and reset.
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Register writes.
  acm_sfr_if.sink                    bus,
  // Assembled word.
  output logic [ACM_WORD_W-1:0]      word
);

  logic [7:0] high_ff;
  logic [7:0] mid_ff;
  logic [7:0] low_ff;

  if (ACM_WORD_W != 3 * ACM_BYTE_W) begin : g_chk
    $error("Calibration word must be exactly three bytes.");
  end

  // Each byte takes a write to its own address.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      high_ff <= RST_HIGH;
      mid_ff  <= ACM_RST_ZERO;
      low_ff  <= ACM_RST_ZERO;
    end else if (bus.ce && bus.wr) begin
      if (bus.addr == ADDR_HIGH) high_ff <= bus.wdata;
      if (bus.addr == ADDR_MID)  mid_ff  <= bus.wdata;
      if (bus.addr == ADDR_LOW)  low_ff  <= bus.wdata;
    end
  end

  // The bytes form one word for the filter arithmetic.
  assign word = {high_ff, mid_ff, low_ff}; // see RQ17

endmodule : acm_cal_word

// [verif/acm_top_tb.sv]
// Self-checking testbench for the converter register block.
// Assumes the register port is driven by the bench, one access at a time, with no partner model.
module acm_top_tb
  import acm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk, resetn, ce, sfr_wr, sfr_rd, sfr_rvalid, main_load, fast_load;
  logic        pos_to_ground, pos_to_temp, neg_to_ground, neg_to_temp, temp_sensor_en;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, pos_pin_sel, neg_pin_sel;
  logic [23:0] main_data, fast_data, offset_word, gain_word;
  int          miscompares = 0;
  int          compares    = 0;
  logic [7:0]  regs [13] = '{ACM_ADDR_GAIN_LOW, ACM_ADDR_GAIN_MID, ACM_ADDR_GAIN_HIGH, ACM_ADDR_OFS_LOW,
                             ACM_ADDR_OFS_MID, ACM_ADDR_OFS_HIGH, ACM_ADDR_MAIN_LOW, ACM_ADDR_MAIN_MID,
                             ACM_ADDR_MAIN_HIGH, ACM_ADDR_FAST_LOW, ACM_ADDR_FAST_MID, ACM_ADDR_FAST_HIGH,
                             ACM_ADDR_SELECT};
  logic [7:0]  vals [6];

  acm_top acm_top_i (.mclk(mclk), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .main_load(main_load), .main_data(main_data), .fast_load(fast_load), .fast_data(fast_data),
    .offset_word(offset_word), .gain_word(gain_word), .pos_pin_sel(pos_pin_sel),
    .pos_to_ground(pos_to_ground), .pos_to_temp(pos_to_temp), .neg_pin_sel(neg_pin_sel),
    .neg_to_ground(neg_to_ground), .neg_to_temp(neg_to_temp), .temp_sensor_en(temp_sensor_en));

  // Clock of 4 ns period.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Compares one value and reports a difference at once.
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // One write strobe, taken at the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  // One read strobe; the answer stands in the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    chk("rvalid", sfr_rvalid, 1'b1);
    chk($sformatf("reg %h", a), sfr_rdata, exp);
  endtask : rd

  // Expected routing of one input: pin one-hot, ground, temperature sensor.
  function automatic logic [9:0] mux_exp(input logic [3:0] c);
    if (c <= 4'h7) return {8'h01 << c, 2'b00};
    if (c == 4'hf) return {8'h00, 2'b01};
    return {8'h00, 2'b10};
  endfunction : mux_exp

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    #(20000 * 4);
    miscompares++;
    conclude();
  end

  // Main sequence of tests.
  initial begin
    {ce, sfr_wr, sfr_rd, main_load, fast_load} = 5'b10000;
    {sfr_addr, sfr_wdata, main_data, fast_data} = '0;
    resetn = 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    resetn = 1'b1;
    // Reset values of every register and of the outputs built from them.
    chk("offset_word", offset_word, 24'h000000);
    chk("gain_word", gain_word, 24'h800000);
    chk("mux", {pos_pin_sel, neg_pin_sel, temp_sensor_en}, 17'h00202);
    for (int k = 0; k < 13; k++) rd(regs[k], (k == 2) ? 8'h80 : 8'h00);
    $display("test reset done");
    // Calibration bytes written, read back and assembled into words.
    for (int k = 0; k < 6; k++) vals[k] = {k[3:0] + 4'h1, 4'ha - k[3:0]};
    for (int k = 0; k < 6; k++) wr(regs[k], vals[k]);
    for (int k = 0; k < 6; k++) rd(regs[k], vals[k]);
    chk("gain_word", gain_word, {vals[2], vals[1], vals[0]});
    chk("offset_word", offset_word, {vals[5], vals[4], vals[3]});
    @(posedge mclk);
    #1;
    chk("rvalid low", sfr_rvalid, 1'b0);
    $display("test calibration done");
    // Filter loads split into bytes, with a write to the main high byte in the load cycle.
    @(posedge mclk);
    #1;
    {main_load, fast_load} = 2'b11;
    main_data = 24'h123456;
    fast_data = 24'hc9a5e1;
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, ACM_ADDR_MAIN_HIGH, 8'hff};
    @(posedge mclk);
    #1;
    {main_load, fast_load, sfr_wr} = 3'b000;
    {sfr_rd, sfr_addr} = {1'b1, ACM_ADDR_MAIN_LOW};
    @(posedge mclk);
    #1;
    {sfr_rd, fast_load} = 2'b01;
    chk("main low at once", sfr_rdata, 8'h56);
    @(posedge mclk);
    #1;
    {sfr_rd, fast_load, sfr_addr} = {2'b10, ACM_ADDR_FAST_LOW};
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    chk("fast low at once", sfr_rdata, 8'he1);
    rd(ACM_ADDR_MAIN_HIGH, 8'h12);
    rd(ACM_ADDR_MAIN_MID, 8'h34);
    rd(ACM_ADDR_MAIN_LOW, 8'h56);
    rd(ACM_ADDR_FAST_HIGH, 8'hc9);
    rd(ACM_ADDR_FAST_MID, 8'ha5);
    rd(ACM_ADDR_FAST_LOW, 8'he1);
    $display("test results done");
    // Single-ended pick: a pin on the positive side, ground on the negative side.
    wr(ACM_ADDR_SELECT, 8'h39);
    chk("single pos", {pos_pin_sel, pos_to_ground, pos_to_temp}, mux_exp(4'h3));
    chk("single neg", {neg_pin_sel, neg_to_ground, neg_to_temp}, mux_exp(4'h9));
    // Every code on each input while the other input stays fixed.
    for (int i = 0; i < 16; i++) begin
      wr(ACM_ADDR_SELECT, {i[3:0], 4'h8});
      chk("pos", {pos_pin_sel, pos_to_ground, pos_to_temp}, mux_exp(i[3:0]));
      chk("neg held", {neg_pin_sel, neg_to_ground, neg_to_temp}, mux_exp(4'h8));
      chk("temp_en", temp_sensor_en, i == 15);
      wr(ACM_ADDR_SELECT, {4'h2, i[3:0]});
      chk("neg", {neg_pin_sel, neg_to_ground, neg_to_temp}, mux_exp(i[3:0]));
      chk("pos held", {pos_pin_sel, pos_to_ground, pos_to_temp}, mux_exp(4'h2));
      chk("temp_en", temp_sensor_en, i == 15);
    end
    rd(ACM_ADDR_SELECT, 8'h2f);
    $display("test multiplexer done");
    // Unmapped place and a write with the clock enable low.
    wr(8'h00, 8'h77);
    rd(8'h00, 8'h00);
    @(posedge mclk);
    #1;
    ce = 1'b0;
    wr(ACM_ADDR_GAIN_LOW, 8'h55);
    ce = 1'b1;
    rd(ACM_ADDR_GAIN_LOW, vals[0]);
    // A write followed at once by a read of the same byte.
    @(posedge mclk);
    #1;
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, ACM_ADDR_GAIN_LOW, 8'h3c};
    @(posedge mclk);
    #1;
    {sfr_wr, sfr_rd} = 2'b01;
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    chk("gain low at once", sfr_rdata, 8'h3c);
    $display("test refusals done");
    conclude();
  end
endmodule : acm_top_tb
